// >>> pkg/tw_pkg.sv
// Shared constants, types and the mode decoder for the 8-bit waveform timer.
// Assumes a single 200 MHz clock domain and an APB register port of 32 bits.
package tw_pkg;

   // Register byte offsets on the APB port.
   localparam logic [7:0] TW_OFF_CTRL_A = 8'h00;
   localparam logic [7:0] TW_OFF_CTRL_B = 8'h04;
   localparam logic [7:0] TW_OFF_CMP_A  = 8'h08;
   localparam logic [7:0] TW_OFF_CMP_B  = 8'h0c;
   localparam logic [7:0] TW_OFF_COUNT  = 8'h10;
   localparam logic [7:0] TW_OFF_STAT   = 8'h14;
   localparam logic [7:0] TW_OFF_MASK   = 8'h18;

   // Field positions.
   localparam int TW_ACT_A_LSB = 6;
   localparam int TW_ACT_B_LSB = 4;
   localparam int TW_HIGH_BIT  = 3;
   localparam int TW_CS_LSB    = 0;
   localparam int TW_ST_OVF    = 0;
   localparam int TW_ST_MA     = 1;
   localparam int TW_ST_MB     = 2;

   // Value after reset, control A writable-bit mask and fixed counter landmarks.
   localparam logic [7:0] TW_REG_RST  = 8'h00;
   localparam logic [7:0] TW_CTRL_A_RW = 8'hf3;
   localparam logic [7:0] TW_MAX      = 8'hff;
   localparam logic [7:0] TW_BOTTOM   = 8'h00;

   // Prescaler tap masks for the count enable.
   localparam logic [9:0] TW_DIV8    = 10'h007;
   localparam logic [9:0] TW_DIV64   = 10'h03f;
   localparam logic [9:0] TW_DIV256  = 10'h0ff;
   localparam logic [9:0] TW_DIV1024 = 10'h3ff;

   typedef enum logic [1:0] {TW_NORMAL, TW_CTC, TW_FAST, TW_PHASE} tw_kind_e;

   typedef struct packed {
      tw_kind_e kind;
      logic     top_cmp;
      logic     pwm;
      logic     ovf_top;
   } tw_mode_s;

   // Decodes the three-bit mode code; reserved codes fall back to normal.
   function automatic tw_mode_s tw_decode(input logic [2:0] code);
      tw_mode_s m;
      m = '{TW_NORMAL, 1'b0, 1'b0, 1'b0};
      case (code)
         3'h1: m = '{TW_PHASE, 1'b0, 1'b1, 1'b0};
         3'h2: m = '{TW_CTC, 1'b1, 1'b0, 1'b0};
         3'h3: m = '{TW_FAST, 1'b0, 1'b1, 1'b0};
         3'h5: m = '{TW_PHASE, 1'b1, 1'b1, 1'b0};
         3'h7: m = '{TW_FAST, 1'b1, 1'b1, 1'b1};
         default: m = '{TW_NORMAL, 1'b0, 1'b0, 1'b0};
      endcase
      return m;
   endfunction : tw_decode

endpackage : tw_pkg

// >>> rtl/tw_timer.sv
// 8-bit timer with waveform generation, two compare outputs and an APB register port.
// Assumes APB master on CLK_I; pin direction lives in the port logic outside.
// Function
// - Nonzero action field connects output to pin, except code 01 in PWM modes unless channel A with high bit
// - Non-PWM actions: off, toggle, clear, set
// - Fast PWM A: clear/set on match, inverse at TOP
// - PWM A code 01 toggles only with high bit
// - Fast PWM B like A; code 01 reserved
// - Phase PWM A: 10 clears up, sets down
// - Phase PWM B: 11 sets up, clears down
// - Compare equal TOP acts at TOP instead
// - Control A bits 3:2 read zero
// - Mode code from high bit and low bits
// - Mode code decode; 4 and 6 reserved
// - TOP is 0xFF or compare A
// - PWM modes buffer compare updates until TOP
// - Overflow at MAX, BOTTOM or TOP per mode
// - Fast PWM wraps to zero after TOP
// - Phase PWM counts up, turns at TOP, down
`timescale 1ns/1ps
`default_nettype none
module tw_timer
   import tw_pkg::*;
(
   input  wire logic        CLK_I,
   input  wire logic        RSTN_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic [31:0]      PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   output logic             WAVE_OUT_A_O,
   output logic             WAVE_OUT_B_O,
   output logic             WAVE_CONN_A_O,
   output logic             WAVE_CONN_B_O,
   output logic             IRQ_O
);

   logic [7:0]  ctrl_a_reg, ctrl_a_next;
   logic [7:0]  ctrl_b_reg, ctrl_b_next;
   logic [7:0]  cmp_buf_reg [2];
   logic [7:0]  cmp_buf_next [2];
   logic [7:0]  cmp_act_reg [2];
   logic [7:0]  cmp_act_next [2];
   logic [7:0]  count_reg, count_next;
   logic        up_reg, up_next;
   logic [9:0]  pre_reg, pre_next;
   logic [2:0]  stat_reg, stat_next;
   logic [2:0]  mask_reg, mask_next;
   logic [2:0]  rdclr_reg, rdclr_next;
   logic [31:0] prdata_reg, prdata_next;
   logic        out_reg [2];
   logic        out_next [2];
   logic        conn [2];
   logic [1:0]  act [2];
   logic        match [2];
   tw_mode_s    mode;
   logic [2:0]  mode_code;
   logic [7:0]  top;
   logic        tick;
   logic        at_top;
   logic        setup;
   logic        access;
   logic        mapped;
   logic        wr;
   logic [2:0]  events;
   logic [31:0] rd_mux;

   // Mode decode and shared timing terms.
   assign mode_code = {ctrl_b_reg[TW_HIGH_BIT], ctrl_a_reg[1:0]};
   assign mode      = tw_decode(mode_code);
   assign top       = mode.top_cmp ? cmp_act_reg[0] : TW_MAX;
   assign at_top    = tick && (count_reg == top);
   assign act[0]    = ctrl_a_reg[TW_ACT_A_LSB +: 2];
   assign act[1]    = ctrl_a_reg[TW_ACT_B_LSB +: 2];
   assign match[0]  = tick && (count_reg == cmp_act_reg[0]);
   assign match[1]  = tick && (count_reg == cmp_act_reg[1]);

   // Count enable from the prescaler, selected by the clock-select field.
   always_comb begin
      pre_next = pre_reg + 10'h001;
      case (ctrl_b_reg[TW_CS_LSB +: 3])
         3'h1:    tick = 1'b1;
         3'h2:    tick = (pre_reg & TW_DIV8) == TW_DIV8;
         3'h3:    tick = (pre_reg & TW_DIV64) == TW_DIV64;
         3'h4:    tick = (pre_reg & TW_DIV256) == TW_DIV256;
         3'h5:    tick = (pre_reg & TW_DIV1024) == TW_DIV1024;
         default: tick = 1'b0;
      endcase
   end

   // Counter sequence, direction and compare buffering.
   always_comb begin
      count_next = count_reg;
      up_next    = up_reg;
      if (tick) begin
         case (mode.kind)
            TW_FAST:  count_next = (count_reg == top) ? TW_BOTTOM : count_reg + 8'h01;
            TW_CTC:   count_next = (count_reg == cmp_act_reg[0]) ? TW_BOTTOM : count_reg + 8'h01;
            TW_PHASE: begin
               if (up_reg) begin
                  if (count_reg == top) begin
                     up_next    = 1'b0;
                     count_next = count_reg - 8'h01;
                  end else begin
                     count_next = count_reg + 8'h01;
                  end
               end else if (count_reg == TW_BOTTOM) begin
                  up_next    = 1'b1;
                  count_next = count_reg + 8'h01;
               end else begin
                  count_next = count_reg - 8'h01;
               end
            end
            default:  count_next = count_reg + 8'h01;
         endcase
      end
      if (mode.kind != TW_PHASE) begin
         up_next = 1'b1;
      end
      if (wr && PADDR_I == TW_OFF_COUNT) begin
         count_next = PWDATA_I[7:0];
      end
      for (int i = 0; i < 2; i++) begin
         cmp_act_next[i] = (!mode.pwm || at_top) ? cmp_buf_reg[i] : cmp_act_reg[i];
      end
   end

   // Compare outputs, one action decoder per channel.
   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_chan
         logic eq_top;
         assign eq_top = (cmp_act_reg[ch] == top);
         // Pin connection: code 01 in PWM modes only for channel A with high bit.
         assign conn[ch] = (act[ch] != 2'b00) &&
                           !(mode.pwm && act[ch] == 2'b01 &&
                             (ch == 1 || !ctrl_b_reg[TW_HIGH_BIT]));
         always_comb begin
            out_next[ch] = out_reg[ch];
            if (!mode.pwm) begin
               if (match[ch]) begin
                  case (act[ch])
                     2'b01:   out_next[ch] = !out_reg[ch];
                     2'b10:   out_next[ch] = 1'b0;
                     2'b11:   out_next[ch] = 1'b1;
                     default: out_next[ch] = out_reg[ch];
                  endcase
               end
            end else if (!act[ch][1]) begin
               if (conn[ch] && match[ch]) begin
                  out_next[ch] = !out_reg[ch];
               end
            end else if (mode.kind == TW_FAST) begin
               if (at_top) begin
                  out_next[ch] = !act[ch][0];
               end else if (match[ch] && !eq_top) begin
                  out_next[ch] = act[ch][0];
               end
            end else begin
               if (match[ch] && eq_top) begin
                  out_next[ch] = act[ch][0];
               end else if (match[ch]) begin
                  out_next[ch] = up_reg ? act[ch][0] : !act[ch][0];
               end
            end
         end
         always_ff @(posedge CLK_I) begin
            if (!RSTN_I) begin
               out_reg[ch] <= 1'b0;
            end else begin
               out_reg[ch] <= out_next[ch];
            end
         end
      end
   endgenerate

   // APB decode; the slave answers in the first access cycle.
   assign setup     = PSEL_I && !PENABLE_I;
   assign access    = PSEL_I && PENABLE_I;
   assign wr        = access && PWRITE_I;
   assign mapped    = (PADDR_I[1:0] == 2'b00) && (PADDR_I <= TW_OFF_MASK);
   assign PREADY_O  = access;
   assign PSLVERR_O = access && !mapped;

   // Read multiplexer; reserved control bits read zero.
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (PADDR_I)
         TW_OFF_CTRL_A: rd_mux[7:0] = ctrl_a_reg & TW_CTRL_A_RW;
         TW_OFF_CTRL_B: rd_mux[7:0] = ctrl_b_reg;
         TW_OFF_CMP_A:  rd_mux[7:0] = cmp_buf_reg[0];
         TW_OFF_CMP_B:  rd_mux[7:0] = cmp_buf_reg[1];
         TW_OFF_COUNT:  rd_mux[7:0] = count_reg;
         TW_OFF_STAT:   rd_mux[2:0] = stat_reg;
         TW_OFF_MASK:   rd_mux[2:0] = mask_reg;
         default:       rd_mux = 32'h0000_0000;
      endcase
   end

   // Register writes, read-to-clear status and sticky events.
   always_comb begin
      ctrl_a_next     = ctrl_a_reg;
      ctrl_b_next     = ctrl_b_reg;
      cmp_buf_next[0] = cmp_buf_reg[0];
      cmp_buf_next[1] = cmp_buf_reg[1];
      mask_next       = mask_reg;
      prdata_next     = prdata_reg;
      rdclr_next      = rdclr_reg;
      if (setup && !PWRITE_I) begin
         prdata_next = rd_mux;
         rdclr_next  = (PADDR_I == TW_OFF_STAT) ? stat_reg : 3'h0;
      end
      if (wr) begin
         case (PADDR_I)
            TW_OFF_CTRL_A: ctrl_a_next = PWDATA_I[7:0] & TW_CTRL_A_RW;
            TW_OFF_CTRL_B: ctrl_b_next = PWDATA_I[7:0];
            TW_OFF_CMP_A:  cmp_buf_next[0] = PWDATA_I[7:0];
            TW_OFF_CMP_B:  cmp_buf_next[1] = PWDATA_I[7:0];
            TW_OFF_MASK:   mask_next = PWDATA_I[2:0];
            default:       mask_next = mask_reg;
         endcase
      end
      events[TW_ST_OVF] = tick && (mode.kind == TW_PHASE ? count_reg == TW_BOTTOM :
                          mode.ovf_top ? count_reg == top : count_reg == TW_MAX);
      events[TW_ST_MA]  = match[0];
      events[TW_ST_MB]  = match[1];
      stat_next = stat_reg;
      if (access && !PWRITE_I) begin
         stat_next  = stat_reg & ~rdclr_reg;
         rdclr_next = 3'h0;
      end
      stat_next = stat_next | events;
   end

   // State registers.
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         ctrl_a_reg     <= TW_REG_RST;
         ctrl_b_reg     <= TW_REG_RST;
         cmp_buf_reg[0] <= TW_REG_RST;
         cmp_buf_reg[1] <= TW_REG_RST;
         cmp_act_reg[0] <= TW_REG_RST;
         cmp_act_reg[1] <= TW_REG_RST;
         count_reg      <= TW_REG_RST;
         up_reg         <= 1'b1;
         pre_reg        <= 10'h000;
         stat_reg       <= 3'h0;
         mask_reg       <= 3'h0;
         rdclr_reg      <= 3'h0;
         prdata_reg     <= 32'h0000_0000;
      end else begin
         ctrl_a_reg     <= ctrl_a_next;
         ctrl_b_reg     <= ctrl_b_next;
         cmp_buf_reg[0] <= cmp_buf_next[0];
         cmp_buf_reg[1] <= cmp_buf_next[1];
         cmp_act_reg[0] <= cmp_act_next[0];
         cmp_act_reg[1] <= cmp_act_next[1];
         count_reg      <= count_next;
         up_reg         <= up_next;
         pre_reg        <= pre_next;
         stat_reg       <= stat_next;
         mask_reg       <= mask_next;
         rdclr_reg      <= rdclr_next;
         prdata_reg     <= prdata_next;
      end
   end

   // Outputs; direction for the pins is the port logic's job.
   assign PRDATA_O      = prdata_reg;
   assign WAVE_OUT_A_O  = out_reg[0];
   assign WAVE_OUT_B_O  = out_reg[1];
   assign WAVE_CONN_A_O = conn[0];
   assign WAVE_CONN_B_O = conn[1];
   assign IRQ_O         = |(stat_reg & mask_reg);

   // Checks of the timer behaviour.
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RSTN_I);

   AST_CTRL_RESERVED: assert property (setup && !PWRITE_I && PADDR_I == TW_OFF_CTRL_A
      |=> PRDATA_O[3:2] == 2'b00)
      else $error("Reserved control bits read nonzero.");
   AST_MODE_CODE: assert property (ctrl_a_reg[1:0] == 2'b10 && !ctrl_b_reg[TW_HIGH_BIT] |-> mode.kind == TW_CTC)
      else $error("Low bits 10 with high bit clear is not clear-on-match.");
   AST_RESERVED_CODE: assert property (mode_code == 3'h6 |-> mode.kind == TW_NORMAL && !mode.pwm)
      else $error("Reserved mode code not treated as normal.");
   AST_TOP_FIXED: assert property (!mode.top_cmp |-> top == TW_MAX)
      else $error("TOP not 0xFF in a fixed-TOP mode.");
   AST_BUF_HOLD: assert property (mode.pwm && !at_top ##1 mode.pwm |-> $stable(cmp_act_reg[0]))
      else $error("Compare A changed away from TOP in a PWM mode.");
   AST_OVF_PHASE: assert property (mode.kind == TW_PHASE && tick && count_reg == TW_BOTTOM
      |=> stat_reg[TW_ST_OVF])
      else $error("Overflow flag not set at BOTTOM in phase-correct mode.");
   AST_FAST_WRAP: assert property (mode.kind == TW_FAST && at_top && !wr |=> count_reg == TW_BOTTOM)
      else $error("Fast PWM counter did not wrap after TOP.");
   AST_PHASE_TURN: assert property (mode.kind == TW_PHASE && up_reg && at_top && !wr
      ##1 mode.kind == TW_PHASE |-> !up_reg)
      else $error("Phase-correct counter did not turn at TOP.");
   AST_CTC_CLEAR: assert property (mode.kind == TW_CTC && match[0] && !wr |=> count_reg == TW_BOTTOM)
      else $error("Clear-on-match counter did not clear after match A.");
   AST_NONPWM_TOGGLE: assert property (!mode.pwm && act[0] == 2'b01 && match[0]
      |=> out_reg[0] != $past(out_reg[0]))
      else $error("Channel A did not toggle on match.");
   AST_FAST_SET_TOP: assert property (mode.kind == TW_FAST && act[0] == 2'b10 && at_top |=> WAVE_OUT_A_O)
      else $error("Fast PWM channel A not set at TOP.");
   AST_PWM_A_OFF: assert property (mode.pwm && act[0] == 2'b01 && !ctrl_b_reg[TW_HIGH_BIT] |-> !WAVE_CONN_A_O)
      else $error("Channel A code 01 connected without high bit.");
   AST_PWM_B_RSVD: assert property (mode.pwm && act[1] == 2'b01 |-> !WAVE_CONN_B_O)
      else $error("Channel B reserved code connected the pin.");
   AST_PHASE_A_UP: assert property (mode.kind == TW_PHASE && act[0] == 2'b10 && match[0] && up_reg
      && cmp_act_reg[0] != top |=> !WAVE_OUT_A_O)
      else $error("Phase PWM channel A not cleared on up match.");
   AST_PHASE_B_DOWN: assert property (mode.kind == TW_PHASE && act[1] == 2'b11 && match[1] && !up_reg
      |=> !WAVE_OUT_B_O)
      else $error("Phase PWM channel B not cleared on down match.");
   AST_EQ_TOP_IGNORE: assert property (mode.kind == TW_FAST && act[1] == 2'b10 && cmp_act_reg[1] == top
      && at_top |=> WAVE_OUT_B_O)
      else $error("Channel B compare at TOP did not act at TOP.");
   AST_CONNECT: assert property (act[1] == 2'b00 |-> !WAVE_CONN_B_O)
      else $error("Channel B connected with zero action.");

   COV_FAST_WRAP: cover property (mode.kind == TW_FAST && at_top);
   COV_PHASE_TURN: cover property (mode.kind == TW_PHASE && up_reg && at_top);
   COV_CTC_MATCH: cover property (mode.kind == TW_CTC && match[0]);
   COV_IRQ: cover property (IRQ_O);

endmodule : tw_timer
`default_nettype wire

// >>> dv/tw_timer_bench.sv
// Self-checking testbench for the 8-bit waveform timer, driving its APB port directly.
// Assumes the timer answers APB with zero wait states and registers its waveform outputs.
`timescale 1ns/1ps
`default_nettype none
module tw_timer_bench
   import tw_pkg::*;
   ;
   logic        clk;
   logic        rstn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        out_a;
   logic        out_b;
   logic        conn_a;
   logic        conn_b;
   logic        irq;
   logic [31:0] rd_data;
   logic        rd_err;
   logic        irq_s;
   logic [31:0] st;
   logic [31:0] cnt;
   int          n_fail;
   int          num_checks;

   // Device under test with every input driven by the bench.
   tw_timer DUT (.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .WAVE_OUT_A_O(out_a), .WAVE_OUT_B_O(out_b), .WAVE_CONN_A_O(conn_a), .WAVE_CONN_B_O(conn_b),
      .IRQ_O(irq));

   // The 200 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Counts a comparison and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; read data and error are taken at the edge where ready is seen.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         n_fail++;
         $display("APB ready never came at t=%0t", $time);
      end
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   // Loads compares and counter while stopped, runs at full rate, stops, then reads status and count.
   task automatic run(input logic [7:0] ca, input logic hb, input logic [7:0] ma, input logic [7:0] mb,
                      input logic [7:0] ld, input int nc, input logic buf_on);
      apb(1'b1, TW_OFF_CTRL_B, 32'h0);
      apb(1'b1, TW_OFF_CTRL_A, {24'h0, ca[7:2], buf_on ? ca[1:0] : 2'b00});
      apb(1'b1, TW_OFF_CMP_A, {24'h0, ma});
      apb(1'b1, TW_OFF_CMP_B, {24'h0, mb});
      apb(1'b1, TW_OFF_COUNT, {24'h0, ld});
      apb(1'b0, TW_OFF_STAT, 32'h0);
      apb(1'b1, TW_OFF_CTRL_A, {24'h0, ca});
      apb(1'b1, TW_OFF_CTRL_B, {28'h0, hb, 3'h1});
      repeat (nc) @(posedge clk);
      apb(1'b1, TW_OFF_CTRL_B, {28'h0, hb, 3'h0});
      irq_s = irq;
      apb(1'b0, TW_OFF_STAT, 32'h0);
      st = rd_data;
      apb(1'b0, TW_OFF_COUNT, 32'h0);
      cnt = rd_data;
   endtask : run

   // Reset values, reserved bits, pin override and an unmapped address.
   task automatic t_regs();
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk(rd_data, 32'h0);
      end
      apb(1'b1, TW_OFF_CTRL_A, 32'hff);
      apb(1'b0, TW_OFF_CTRL_A, 32'h0);
      chk(rd_data, {24'h0, TW_CTRL_A_RW});
      chk({30'h0, conn_a, conn_b}, 32'h3);
      apb(1'b0, 8'h1c, 32'h0);
      chk({rd_data[30:0], rd_err}, 32'h1);
      apb(1'b1, TW_OFF_CTRL_A, 32'h0);
      chk({30'h0, conn_a, conn_b}, 32'h0);
      $display("test regs done");
   endtask : t_regs

   // Every mode code: count shape, flags and the overflow interrupt.
   task automatic t_modes();
      logic [2:0] code;
      int         cls;
      apb(1'b1, TW_OFF_MASK, 32'h1);
      for (int c = 0; c < 8; c++) begin
         code = c[2:0];
         run({6'h0, code[1:0]}, code[2], 8'h80, 8'h78, 8'h70, 36, 1'b0);
         chk(st, {29'h0, 2'b11, code == 3'h7});
         chk({31'h0, irq_s}, {31'h0, code == 3'h7});
         chk({31'h0, irq}, 32'h0);
         cls = (cnt[7:0] >= 8'h90) ? 2 : (cnt[7:0] >= 8'h40) ? 1 : 0;
         chk(cls, (code == 3'h2 || code == 3'h7) ? 0 : (code == 3'h5) ? 1 : 2);
         if (code != 3'h5 && code != 3'h7) begin
            run({6'h0, code[1:0]}, code[2], 8'h80, 8'h78, 8'hf0, 36, 1'b0);
            chk({31'h0, st[0]}, {31'h0, code != 3'h1});
         end
      end
      apb(1'b1, TW_OFF_MASK, 32'h0);
      run(8'h03, 1'b1, 8'h80, 8'h78, 8'h70, 36, 1'b0);
      chk({30'h0, irq_s, st[0]}, 32'h1);
      $display("test modes done");
   endtask : t_modes

   // Compare actions outside the PWM modes.
   task automatic t_plain();
      logic [1:0] acts [4] = '{2'b11, 2'b01, 2'b01, 2'b10};
      logic       ex [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 4; i++) begin
         run({acts[i], acts[i], 4'h0}, 1'b0, 8'h80, 8'h78, 8'h70, 36, 1'b0);
         chk({28'h0, conn_a, conn_b, out_a, out_b}, {28'h0, 2'b11, ex[i], ex[i]});
      end
      run(8'h00, 1'b0, 8'h80, 8'h78, 8'h70, 36, 1'b0);
      chk({30'h0, conn_a, conn_b}, 32'h0);
      $display("test plain done");
   endtask : t_plain

   // Fast PWM actions, toggle only with the high mode bit, reserved code on channel B, compare B at TOP.
   task automatic t_fast();
      logic [1:0] acts [4] = '{2'b11, 2'b11, 2'b10, 2'b10};
      logic [7:0] lds [4] = '{8'h70, 8'hf0, 8'h70, 8'hf0};
      logic       ex [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
      for (int i = 0; i < 4; i++) begin
         run({acts[i], acts[i], 4'h3}, 1'b0, 8'h80, 8'h78, lds[i], 36, 1'b0);
         chk({30'h0, out_a, out_b}, {30'h0, ex[i], ex[i]});
      end
      run(8'h53, 1'b1, 8'h80, 8'h78, 8'h70, 36, 1'b0);
      chk({28'h0, conn_a, conn_b, out_a, out_b}, 32'h9);
      run(8'h53, 1'b0, 8'h80, 8'h78, 8'h70, 36, 1'b0);
      chk({30'h0, conn_a, conn_b}, 32'h0);
      run(8'hf3, 1'b1, 8'h80, 8'h80, 8'h70, 36, 1'b0);
      chk({30'h0, out_a, out_b}, 32'h0);
      run(8'ha3, 1'b1, 8'h80, 8'h80, 8'h70, 36, 1'b0);
      chk({30'h0, out_a, out_b}, 32'h3);
      $display("test fast done");
   endtask : t_fast

   // Phase-correct actions on the way up and on the way down.
   task automatic t_phase();
      logic [3:0] acts [4] = '{4'hb, 4'hb, 4'he, 4'he};
      logic [7:0] lds [4] = '{8'h70, 8'hf8, 8'h70, 8'hf8};
      int         ncs [4] = '{36, 150, 36, 150};
      logic [1:0] ex [4] = '{2'b01, 2'b10, 2'b10, 2'b01};
      for (int i = 0; i < 4; i++) begin
         run({acts[i], 4'h1}, 1'b0, 8'h80, 8'h78, lds[i], ncs[i], 1'b0);
         chk({30'h0, out_a, out_b}, {30'h0, ex[i]});
      end
      $display("test phase done");
   endtask : t_phase

   // A compare write waits for TOP in PWM modes but acts at once in normal mode.
   task automatic t_buffer();
      run(8'h03, 1'b0, 8'h80, 8'h20, 8'h10, 36, 1'b1);
      chk({31'h0, st[2]}, 32'h0);
      run(8'h00, 1'b0, 8'h80, 8'h20, 8'h10, 36, 1'b0);
      chk({31'h0, st[2]}, 32'h1);
      $display("test buffer done");
   endtask : t_buffer

   // Each prescaled rate gives exactly ten ticks over ten of its periods.
   task automatic t_presc();
      int divs [4] = '{8, 64, 256, 1024};
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, TW_OFF_CTRL_B, 32'h0);
         apb(1'b1, TW_OFF_CTRL_A, 32'h0);
         apb(1'b1, TW_OFF_COUNT, 32'h0);
         apb(1'b1, TW_OFF_CTRL_B, 32'(i + 2));
         repeat (divs[i] * 10 - 3) @(posedge clk);
         apb(1'b1, TW_OFF_CTRL_B, 32'h0);
         apb(1'b0, TW_OFF_COUNT, 32'h0);
         chk(rd_data, 32'h0000_000a);
      end
      $display("test presc done");
   endtask : t_presc

   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report

   // Cuts a hang short well after the tests should have ended.
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      $display("watchdog expired at t=%0t", $time);
      final_report();
   end

   // Main sequence: reset for three cycles, then every scenario in turn.
   initial begin
      n_fail = 0;
      num_checks = 0;
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_modes();
      t_plain();
      t_fast();
      t_phase();
      t_buffer();
      t_presc();
      final_report();
   end
endmodule : tw_timer_bench
`default_nettype wire
